// File: src/kps_pkg.sv
/*
 * Package for the keypad scanner serial target port and scan power modes.
 * Assumes one system clock domain plus a serial bus clock domain.
 */
package kps_pkg;

    localparam logic [6:0] KPS_DEV_ADDR   = 7'h34;
    localparam int         KPS_REG_COUNT  = 32;
    localparam int         KPS_PTR_W      = 5;
    localparam logic [7:0] KPS_REG_RESET  = 8'h00;
    localparam logic [7:0] KPS_BYTE_ZERO  = 8'h00;
    localparam logic [3:0] KPS_BIT_LAST   = 4'h7;
    localparam logic [3:0] KPS_BIT_ACK    = 4'h8;
    localparam logic [3:0] KPS_BIT_FIRST  = 4'h0;
    localparam int         KPS_ROWS       = 8;
    localparam int         KPS_COLS       = 10;
    localparam logic       KPS_DIR_READ   = 1'b1;

    // Serial link states, one-hot
    typedef enum logic [5:0] {
        KPS_LS_IDLE  = 6'h01,
        KPS_LS_ADDR  = 6'h02,
        KPS_LS_CMD   = 6'h04,
        KPS_LS_WDATA = 6'h08,
        KPS_LS_RDATA = 6'h10,
        KPS_LS_SKIP  = 6'h20
    } kps_link_state_type;

    // Scan power states, one-hot
    typedef enum logic [1:0] {
        KPS_SM_IDLE   = 2'h1,
        KPS_SM_ACTIVE = 2'h2
    } kps_scan_state_type;

    // Register write request crossing into the system domain
    typedef struct packed {
        logic [KPS_PTR_W-1:0] addr;
        logic [7:0]           data;
    } kps_wr_type;

    // Keypad pin drive bundle
    typedef struct packed {
        logic [KPS_COLS-1:0] col_out;
        logic [KPS_COLS-1:0] col_oe_n;
        logic [KPS_ROWS-1:0] row_pullup;
    } kps_pins_type;

endpackage

// File: src/kps_sync.sv
/*
 * Two-flop level synchroniser, parameterised width.
 * Assumes the input is quasi-static relative to the destination clock.
 */
module kps_sync
    import kps_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // First stage feeds only the second
    always_ff @(posedge i_clk) begin
        meta_r <= i_d;
        q_r    <= meta_r;
    end

    assign o_q = q_r;
endmodule

// File: src/kps_top.sv
/*
 * Keypad scanner serial target port with idle/active scan power modes.
 * Serial logic runs on the bus clock pin; registers live in the system
 * domain and writes cross by toggle handshake. Assumes an external
 * scanner reports any-key-down and consumes the wake and scan outputs.
 */
module kps_top
    import kps_pkg::*;
(
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_scl_clk,
    input  wire logic                i_sda,
    output logic                     o_sda,
    output logic                     o_sda_oe_n,
    input  wire logic [KPS_ROWS-1:0] i_rows,
    input  wire logic                i_any_key_down,
    output kps_pins_type             o_pins,
    output logic                     o_osc_en,
    output logic                     o_wake,
    output logic                     o_scan_active,
    output logic                     o_bus_idle
);

    ////////////////////////////////////////////////////////////////////////
    // Reset into the bus clock domain
    logic [1:0] lrst_sync;
    logic       lrst_n;
    kps_sync #(.W(2)) u_lrst (
        .i_clk (i_scl_clk),
        .i_d   ({i_rst_n, lrst_sync[1]}),
        .o_q   (lrst_sync)
    );
    assign lrst_n = lrst_sync[0];

    ////////////////////////////////////////////////////////////////////////
    // START and STOP detection: data edges while clock high
    logic start_tgl_r;
    logic stop_tgl_r;

    // Cleared by the link reset: no bus clock reaches these flops
    always_ff @(negedge i_sda or negedge lrst_n) begin
        if (!lrst_n)
            start_tgl_r <= 1'b0;
        else if (i_scl_clk)
            start_tgl_r <= ~start_tgl_r;
    end

    always_ff @(posedge i_sda or negedge lrst_n) begin
        if (!lrst_n)
            stop_tgl_r <= 1'b0;
        else if (i_scl_clk)
            stop_tgl_r <= ~stop_tgl_r;
    end

    // Seen on the next clock high; bus clock stands still between frames
    logic start_seen_r;
    logic stop_seen_r;
    logic start_ev;
    assign start_ev = start_tgl_r ^ start_seen_r;

    ////////////////////////////////////////////////////////////////////////
    // Serial link state machine, bus clock domain
    kps_link_state_type   lstate_r;
    logic [3:0]           bit_r;
    logic [7:0]           shift_r;
    logic                 dir_r;
    logic [KPS_PTR_W-1:0] ptr_r;
    logic [7:0]           tx_r;
    logic                 wr_tgl_r;
    kps_wr_type           wr_r;
    logic [7:0]           rd_data;
    logic                 sda_low_r;
    logic [7:0]           byte_in;

    assign byte_in = {shift_r[6:0], i_sda};

    always_ff @(posedge i_scl_clk) begin
        if (!lrst_n) begin
            start_seen_r <= start_tgl_r;
            stop_seen_r  <= stop_tgl_r;
        end else begin
            start_seen_r <= start_tgl_r;
            stop_seen_r  <= stop_tgl_r;
        end
    end

    always_ff @(posedge i_scl_clk) begin
        if (!lrst_n) begin
            lstate_r <= KPS_LS_IDLE;
            bit_r    <= KPS_BIT_FIRST;
            shift_r  <= KPS_BYTE_ZERO;
            dir_r    <= 1'b0;
            ptr_r    <= '0;
            wr_tgl_r <= 1'b0;
            wr_r     <= '0;
        end else if (start_ev) begin
            // First address bit sampled with the START clock
            lstate_r <= KPS_LS_ADDR;
            bit_r    <= 4'h1;
            shift_r  <= {7'h00, i_sda};
        end else if (stop_tgl_r ^ stop_seen_r) begin
            lstate_r <= KPS_LS_IDLE;
        end else begin
            bit_r <= (bit_r == KPS_BIT_ACK) ? KPS_BIT_FIRST : bit_r + 4'h1;
            if (bit_r <= KPS_BIT_LAST)
                shift_r <= byte_in;
            case (lstate_r)
                KPS_LS_ADDR: begin
                    if (bit_r == KPS_BIT_LAST) begin
                        dir_r <= i_sda;
                        if (shift_r[6:0] != KPS_DEV_ADDR)
                            lstate_r <= KPS_LS_SKIP;
                    end else if (bit_r == KPS_BIT_ACK) begin
                        lstate_r <= (dir_r == KPS_DIR_READ) ? KPS_LS_RDATA : KPS_LS_CMD;
                    end
                end
                KPS_LS_CMD: begin
                    if (bit_r == KPS_BIT_LAST)
                        ptr_r <= byte_in[KPS_PTR_W-1:0];
                    else if (bit_r == KPS_BIT_ACK)
                        lstate_r <= KPS_LS_WDATA;
                end
                KPS_LS_WDATA: begin
                    if (bit_r == KPS_BIT_LAST) begin
                        wr_r     <= '{addr: ptr_r, data: byte_in};
                        wr_tgl_r <= ~wr_tgl_r;
                        ptr_r    <= ptr_r + 1'b1;
                    end
                end
                KPS_LS_RDATA: begin
                    if (bit_r == KPS_BIT_ACK) begin
                        if (i_sda)
                            lstate_r <= KPS_LS_SKIP;
                        else
                            ptr_r <= ptr_r + 1'b1;
                    end
                end
                KPS_LS_IDLE,
                KPS_LS_SKIP: begin
                    lstate_r <= lstate_r;
                end
                default: begin
                    lstate_r <= KPS_LS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data line drive, changed on the falling bus clock
    // One pull flag, so a single bit crosses into the system domain
    always_ff @(negedge i_scl_clk) begin
        if (!lrst_n) begin
            sda_low_r <= 1'b0;
            tx_r      <= KPS_BYTE_ZERO;
        end else if (bit_r == KPS_BIT_ACK && !start_ev) begin
            // Acknowledge phase
            sda_low_r <= (lstate_r == KPS_LS_ADDR) || (lstate_r == KPS_LS_CMD)
                      || (lstate_r == KPS_LS_WDATA);
        end else if (lstate_r == KPS_LS_RDATA && bit_r == KPS_BIT_FIRST) begin
            // Byte from register at pointer, MSB first
            sda_low_r <= ~rd_data[7];
            tx_r      <= {rd_data[6:0], 1'b0};
        end else if (lstate_r == KPS_LS_RDATA && bit_r <= KPS_BIT_LAST) begin
            sda_low_r <= ~tx_r[7];
            tx_r      <= {tx_r[6:0], 1'b0};
        end else begin
            sda_low_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file, system domain; writes via toggle handshake
    logic [7:0] regs_r [KPS_REG_COUNT];
    logic       wr_tgl_s;
    logic       wr_seen_r;
    kps_sync #(.W(1)) u_wr (
        .i_clk (i_sys_clk),
        .i_d   (wr_tgl_r),
        .o_q   (wr_tgl_s)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wr_seen_r <= 1'b0;
            for (int i = 0; i < KPS_REG_COUNT; i++)
                regs_r[i] <= KPS_REG_RESET;
        end else begin
            wr_seen_r <= wr_tgl_s;
            if (wr_tgl_s != wr_seen_r)
                regs_r[wr_r.addr] <= wr_r.data;         // wr_r stable by then
        end
    end

    // Read path: stored value is static while the link reads it
    assign rd_data = regs_r[ptr_r];

    ////////////////////////////////////////////////////////////////////////
    // Bus idle flag in the system domain
    logic [1:0] lines_s;
    kps_sync #(.W(2)) u_lines (
        .i_clk (i_sys_clk),
        .i_d   ({i_sda, i_scl_clk}),
        .o_q   (lines_s)
    );
    logic       stop_s;
    logic       stop_seen_s_r;
    kps_sync #(.W(1)) u_stop (
        .i_clk (i_sys_clk),
        .i_d   (stop_tgl_r),
        .o_q   (stop_s)
    );
    logic       after_stop_r;
    logic       start_s;
    logic       start_seen_s_r;
    kps_sync #(.W(1)) u_start (
        .i_clk (i_sys_clk),
        .i_d   (start_tgl_r),
        .o_q   (start_s)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            stop_seen_s_r  <= 1'b0;
            start_seen_s_r <= 1'b0;
            after_stop_r   <= 1'b1;
            o_bus_idle     <= 1'b0;
        end else begin
            stop_seen_s_r  <= stop_s;
            start_seen_s_r <= start_s;
            if (stop_s != stop_seen_s_r)
                after_stop_r <= 1'b1;
            else if (start_s != start_seen_s_r)
                after_stop_r <= 1'b0;
            o_bus_idle <= after_stop_r && (&lines_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan power modes
    logic [KPS_ROWS-1:0] rows_s;
    logic                key_s;
    kps_sync #(.W(KPS_ROWS + 1)) u_rows (
        .i_clk (i_sys_clk),
        .i_d   ({i_rows, i_any_key_down}),
        .o_q   ({rows_s, key_s})
    );

    kps_scan_state_type sstate_r;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sstate_r      <= KPS_SM_IDLE;
            o_wake        <= 1'b0;
            o_osc_en      <= 1'b0;
            o_scan_active <= 1'b0;
            o_pins        <= '{col_out: '0, col_oe_n: '0, row_pullup: '1};
        end else begin
            o_wake <= 1'b0;
            case (sstate_r)
                KPS_SM_IDLE: begin
                    o_osc_en      <= 1'b0;
                    o_scan_active <= 1'b0;
                    o_pins        <= '{col_out: '0, col_oe_n: '0, row_pullup: '1};
                    if (!(&rows_s)) begin
                        sstate_r      <= KPS_SM_ACTIVE;
                        o_wake        <= 1'b1;
                        o_osc_en      <= 1'b1;
                        o_scan_active <= 1'b1;
                    end
                end
                KPS_SM_ACTIVE: begin
                    // Releases as soon as scanner reports no key down and all rows read high
                    if (!key_s && (&rows_s)) begin
                        sstate_r      <= KPS_SM_IDLE;
                        o_osc_en      <= 1'b0;
                        o_scan_active <= 1'b0;
                    end
                end
                default: begin
                    sstate_r <= KPS_SM_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain data line: enable low while pulling low
    // Two-flop crossing costs up to three system clocks of drive delay;
    // the bus clock low phase must cover it
    logic pull_s;
    kps_sync #(.W(1)) u_pull (
        .i_clk (i_sys_clk),
        .i_d   (sda_low_r),
        .o_q   (pull_s)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_sda      <= 1'b1;
            o_sda_oe_n <= 1'b1;
        end else begin
            o_sda      <= 1'b0;
            o_sda_oe_n <= ~pull_s;
        end
    end

endmodule

// File: testbench/kps_checker.sv
/* Checker for kps_top: scan modes, bus idle and data line release.
   Sees only the top module's ports; bound at the foot of this file. */
module kps_checker
    import kps_pkg::*;
(
    input wire logic                i_sys_clk,
    input wire logic                i_rst_n,
    input wire logic                i_scl_clk,
    input wire logic                i_sda,
    input wire logic                o_sda_oe_n,
    input wire logic [KPS_ROWS-1:0] i_rows,
    input wire logic                i_any_key_down,
    input wire kps_pins_type        o_pins,
    input wire logic                o_osc_en,
    input wire logic                o_wake,
    input wire logic                o_scan_active,
    input wire logic                o_bus_idle
);
    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////
    idle_pins_a: assert property (!o_scan_active && !$past(o_scan_active) |->
        o_pins == 28'h00000ff) else $error("idle pin drive wrong");
    idle_osc_a: assert property (!o_scan_active && !$past(o_scan_active) |->
        !o_osc_en) else $error("oscillator runs in idle");
    row_wake_a: assert property (!o_scan_active && $fell(&i_rows) |->
        ##3 o_wake && o_osc_en && o_scan_active) else $error("no wake after row low");
    wake_once_a: assert property (o_wake |=> !o_wake && o_scan_active)
        else $error("wake not a single pulse");
    wake_cause_a: assert property ($rose(o_scan_active) |-> !(&$past(i_rows, 3)))
        else $error("wake without row low");
    stay_active_a: assert property ((o_scan_active && i_any_key_down) [*4] |=> o_scan_active)
        else $error("left active with key held");
    back_idle_a: assert property ((o_scan_active && !i_any_key_down && &i_rows) [*2] |->
        ##[0:8] !o_scan_active) else $error("no return to idle");
    idle_rel_a: assert property (o_bus_idle |-> o_sda_oe_n)
        else $error("data driven on idle bus");
    bus_busy_a: assert property ((!(i_sda && i_scl_clk)) [*8] |-> !o_bus_idle)
        else $error("idle flag with a line low");
endmodule

bind kps_top kps_checker kps_checker_i (.i_sys_clk, .i_rst_n, .i_scl_clk, .i_sda, .o_sda_oe_n, .i_rows,
    .i_any_key_down, .o_pins, .o_osc_en, .o_wake, .o_scan_active, .o_bus_idle);

// File: testbench/kps_master.sv
/* Bus master model: serial clock and open-drain data line; each ack
   or read byte is reported on a strobe. Assumes the bench resolves
   the data wire from both drivers with a pull-up. */
module kps_master (
    output logic       o_scl,
    output logic       o_sda,
    output logic       o_stb,
    output logic [7:0] o_res,
    input  wire logic  i_sda
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_stb = 1'b0;
        o_res = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    // Clock runs for reset and frames only, high in between
    task automatic pulses(input int n);
        repeat (n) begin
            #15 o_scl = 1'b0;
            #15 o_scl = 1'b1;
        end
    endtask

    // Low phase stretched to 30 ns: device drive is retimed and slow
    task automatic bit_io(input logic b, output logic s);
        #8 o_sda = b;
        #22 o_scl = 1'b1;
        #1 s = i_sda;
        #14 o_scl = 1'b0;
    endtask

    task automatic start();
        #8 o_sda = 1'b1;
        #22 o_scl = 1'b1;
        #15 o_sda = 1'b0;
        #15 o_scl = 1'b0;
    endtask

    // Clock stays high after STOP; bus is idle from here
    task automatic stop();
        #8 o_sda = 1'b0;
        #22 o_scl = 1'b1;
        #15 o_sda = 1'b1;
    endtask

    task automatic post(input logic [7:0] v);
        o_res = v;
        o_stb = 1'b1;
        #1 o_stb = 1'b0;
    endtask

    task automatic wbyte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        post({7'h00, s});
    endtask

    task automatic rbyte(input logic last);
        logic [7:0] v;
        logic       s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(last, s);
        post(v);
    endtask
endmodule

// File: testbench/tb_kps_top.sv
/* Self-checking bench for kps_top with the bus master model.
   Assumes the checker is bound to kps_top by its own file. */
module tb_kps_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic                         clk, rst_n, any_key, scl, m_sda, sda, sda_o, sda_oe_n;
    logic                         osc_en, wake, scan_act, bus_idle, stb;
    logic [7:0]                   res, p, d0, d1;
    logic [kps_pkg::KPS_ROWS-1:0] rows;
    kps_pkg::kps_pins_type        pins;
    logic [7:0]                   exp_q[$];
    int                           failures, compares, n, k;

    assign sda = (sda_oe_n | sda_o) & m_sda;
    kps_top kps_top_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_scl_clk(scl), .i_sda(sda), .o_sda(sda_o),
        .o_sda_oe_n(sda_oe_n), .i_rows(rows), .i_any_key_down(any_key), .o_pins(pins), .o_osc_en(osc_en),
        .o_wake(wake), .o_scan_active(scan_act), .o_bus_idle(bus_idle));
    kps_master kps_master_i (.o_scl(scl), .o_sda(m_sda), .o_stb(stb), .o_res(res), .i_sda(sda));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        check(exp_q.size(), 32'h0);
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic bound(input int lim);
        if (n >= lim) begin
            failures++;
            close_out();
        end
    endtask

    task automatic xfer(input logic [7:0] b[$], input logic [7:0] ack);
        kps_master_i.start();
        foreach (b[i]) begin
            exp_q.push_back(ack);
            kps_master_i.wbyte(b[i]);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
        xfer('{{kps_pkg::KPS_DEV_ADDR, 1'b0}, a}, 8'h00);
        xfer('{{kps_pkg::KPS_DEV_ADDR, 1'b1}}, 8'h00);
        foreach (e[i]) begin
            exp_q.push_back(e[i]);
            kps_master_i.rbyte(i == e.size() - 1);
        end
        kps_master_i.stop();
    endtask

    always @(posedge stb) begin
        check(res, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        rows = '1;
        any_key = 1'b0;
        failures = 0;
        compares = 0;
        n = $urandom(32'hc165);
        fork
            kps_master_i.pulses(5);
            repeat (20) @(posedge clk);
        join
        #1 rst_n = 1'b1;
        kps_master_i.pulses(4);
        check(pins, 28'h00000ff);
        check({osc_en, scan_act, sda_oe_n, wake}, 4'h2);
        rd(8'($urandom_range(29)), '{8'h00, 8'h00, 8'h00});
        $display("reset test done");
        repeat (3) begin
            p = 8'($urandom_range(29));
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            xfer('{{kps_pkg::KPS_DEV_ADDR, 1'b0}, p, d0, d1}, 8'h00);
            kps_master_i.stop();
            repeat (6) @(posedge clk);
            #1 check(bus_idle, 1'b1);
            xfer('{{kps_pkg::KPS_DEV_ADDR ^ 7'h01, 1'b0}, p, ~d0}, 8'h01);
            kps_master_i.stop();
            rd(p, '{d0, d1});
        end
        $display("register test done");
        repeat (3) begin
            k = $urandom_range(7);
            @(posedge clk);
            #1 rows[k] = 1'b0;
            any_key = 1'b1;
            for (n = 0; n < 9 && wake !== 1'b1; n++) @(negedge clk);
            bound(9);
            check({osc_en, scan_act}, 2'h3);
            @(posedge clk);
            #1 rows = '1;
            repeat (8) @(negedge clk);
            check(scan_act, 1'b1);
            @(posedge clk);
            #1 any_key = 1'b0;
            for (n = 0; n < 20 && scan_act !== 1'b0; n++) @(negedge clk);
            bound(20);
            @(negedge clk);
            check({osc_en, pins}, 29'h00000ff);
        end
        $display("scan test done");
        close_out();
    end
endmodule
